// ---- bench/core_model.sv ----
// Purpose: behavioural core side that acks shown requests and retires handlers
// Assumes: ack comes ack_dly_i + 1 cycles after a line rises; done on done_go_i
// Notes:   done is never sent without an acked handler, like a real core
module core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] req_i,
  input  wire logic [3:0] ack_dly_i,
  input  wire logic       done_go_i,
  output logic            ack_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic [3:0] act_q;
  // ack lasts one cycle so a shown line is never acked twice
  always_ff @(posedge clk_i) begin
    if (rst_i || req_i == 8'h00 || ack_o) begin
      wait_q <= #1 4'h0;
      ack_o  <= #1 1'b0;
    end else if (wait_q >= ack_dly_i) begin
      ack_o  <= #1 1'b1;
    end else begin
      wait_q <= #1 wait_q + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_q <= #1 4'h0;
    end else begin
      act_q <= #1 act_q + {3'h0, ack_o && req_i != 8'h00} - {3'h0, done_o};
    end
    done_o <= #1 !rst_i && done_go_i && act_q != 4'h0 && !done_o;
  end
endmodule

// ---- bench/cpu_interrupt_and_wake_logic_tb_top.sv ----
// Purpose: directed scenarios for routing, nesting, nmi and sleep exits
// Assumes: inputs change 1 ns after the rising edge
// Notes:   each scenario starts from a fresh reset to stay independent
module cpu_interrupt_and_wake_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_wake_pkg::*;
  logic      clk, rst, nmi_en, sleep, ret, ack, done, done_go;
  logic      nmi, wake, asleep, crst, retain;
  src_vec_t  src, en, wake_en, req;
  prio_vec_t prio;
  src_idx_t  nmi_sel;
  prio_t     rprio;
  logic [3:0] dly;
  int        error_cnt, n_checks;

  cpu_interrupt_and_wake_logic u_dut (.core_clk_i(clk), .rst_i(rst), .src_i(src),
    .irq_en_i(en), .irq_prio_i(prio), .nmi_en_i(nmi_en), .nmi_sel_i(nmi_sel),
    .wake_en_i(wake_en), .sleep_req_i(sleep), .ret_mode_i(ret), .irq_ack_i(ack),
    .irq_done_i(done), .nmi_o(nmi), .core_req_o(req), .core_req_prio_o(rprio),
    .wake_o(wake), .core_asleep_o(asleep), .core_rst_o(crst), .ram_retain_o(retain));
  core_model u_core (.clk_i(clk), .rst_i(rst), .req_i(req), .ack_dly_i(dly),
    .done_go_i(done_go), .ack_o(ack), .done_o(done));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task tick;
    @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task tmo(input int k);
    if (k >= 30) begin
      error_cnt++;
      $display("MISMATCH wait exp event got timeout");
      end_sim;
    end
  endtask
  task wreq(output int k);
    for (k = 0; k < 30 && req === 8'h00; k++) tick;
    tmo(k);
  endtask
  task fin;
    done_go = 1'b1;
    tick;
    done_go = 1'b0;
  endtask
  task rst_all;
    rst = 1'b1;
    src = 8'h00;
    en = 8'hff;
    prio = {8{3'h3}};
    nmi_en = 1'b0;
    nmi_sel = 3'h0;
    wake_en = 8'h00;
    sleep = 1'b0;
    ret = 1'b0;
    dly = 4'h0;
    done_go = 1'b0;
    repeat (3) tick;
    rst = 1'b0;
  endtask

  task t_route;
    int k;
    for (int n = 0; n < 8; n++) begin
      rst_all;
      prio[n] = 3'(n);
      src[n] = 1'b1;
      wreq(k);
      chk("latency", 8'h02, 8'(k));
      chk("line", 8'h01 << n, req);
      chk("level", 8'(n), {5'h0, rprio});
      // one more edge so the latency property closes before the next reset
      tick;
    end
  endtask
  task t_nest;
    int k;
    rst_all;
    dly = 4'h3;
    prio[1] = 3'h5;
    prio[6] = 3'h2;
    prio[3] = 3'h0;
    src = 8'h42;
    wreq(k);
    chk("first", 8'h40, req);
    repeat (8) tick;
    chk("held", 8'h00, req);
    src[3] = 1'b1;
    wreq(k);
    chk("preempt", 8'h08, req);
    repeat (8) tick;
    fin;
    repeat (6) tick;
    chk("outranked", 8'h00, req);
    fin;
    wreq(k);
    chk("last", 8'h02, req);
  endtask
  task t_dis;
    int k;
    rst_all;
    en = 8'hef;
    src[4] = 1'b1;
    repeat (6) tick;
    chk("disabled", 8'h00, req);
    en = 8'hff;
    wreq(k);
    chk("enabled", 8'h10, req);
  endtask
  task t_nmi;
    rst_all;
    nmi_en = 1'b1;
    nmi_sel = 3'h5;
    src = 8'h20;
    repeat (2) tick;
    chk("nmi", 8'h01, {7'h0, nmi});
    repeat (4) tick;
    chk("nmi lines", 8'h00, req);
  endtask
  task t_sleep(input logic r);
    int k;
    rst_all;
    wake_en = 8'h01;
    sleep = 1'b1;
    ret = r;
    tick;
    sleep = 1'b0;
    ret = 1'b0;
    src[7] = 1'b1;
    repeat (4) tick;
    chk("asleep", 8'h01, {7'h0, asleep});
    chk("retain", {7'h0, r}, {7'h0, retain});
    chk("no req", 8'h00, req);
    src[0] = 1'b1;
    for (k = 0; k < 30 && wake !== 1'b1; k++) tick;
    tmo(k);
    chk("woken", 8'h00, {7'h0, asleep});
    chk("core rst", {7'h0, r}, {7'h0, crst});
    for (k = 0; k < 30 && crst === 1'b1; k++) tick;
    tmo(k);
    chk("rst len", r ? 8'(CORE_RST_CYC) : 8'h00, 8'(k));
    chk("retain end", 8'h00, {7'h0, retain});
    wreq(k);
    chk("kept", 8'h01, req);
  endtask

  initial begin
    error_cnt = 0;
    n_checks = 0;
    rst_all;
    t_route;
    t_nest;
    t_dis;
    t_nmi;
    t_sleep(1'b0);
    t_sleep(1'b1);
    end_sim;
  end
endmodule

// ---- rtl/cpu_interrupt_and_wake_logic.sv ----
// Purpose: route peripheral interrupts to the core, nest them by priority, wake the core
// Assumes: sources, settings and core handshakes come from logic on core_clk_i
// Notes:   a lone enabled request in run mode is presented two cycles after its source rises
module cpu_interrupt_and_wake_logic (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire irq_wake_pkg::src_vec_t   src_i,
  input  wire irq_wake_pkg::src_vec_t   irq_en_i,
  input  wire irq_wake_pkg::prio_vec_t  irq_prio_i,
  input  wire logic                     nmi_en_i,
  input  wire irq_wake_pkg::src_idx_t   nmi_sel_i,
  input  wire irq_wake_pkg::src_vec_t   wake_en_i,
  input  wire logic                     sleep_req_i,
  input  wire logic                     ret_mode_i,
  input  wire logic                     irq_ack_i,
  input  wire logic                     irq_done_i,
  output logic                          nmi_o,
  output irq_wake_pkg::src_vec_t        core_req_o,
  output irq_wake_pkg::prio_t           core_req_prio_o,
  output logic                          wake_o,
  output logic                          core_asleep_o,
  output logic                          core_rst_o,
  output logic                          ram_retain_o
);
  import irq_wake_pkg::*;

  src_vec_t    src_q;
  src_vec_t    pending_q;
  src_vec_t    active_q;
  src_vec_t    core_req_q;
  prio_t       core_prio_q;
  logic        nmi_q;
  logic        wake_q;
  logic        asleep_q;
  logic        core_rst_q;
  logic        retain_q;
  pwr_state_t  state_q;
  pwr_state_t  state_d;
  logic [RST_CNT_W-1:0] rst_cnt_q;

  src_vec_t    nmi_mask;
  src_vec_t    ack_mask;
  src_vec_t    done_mask;
  src_vec_t    rise;
  src_vec_t    cand;
  src_vec_t    core_req_d;
  logic        win_valid;
  src_idx_t    win_idx;
  prio_t       win_prio;
  logic        act_valid;
  src_idx_t    act_idx;
  prio_t       act_prio;
  logic        run_valid;
  prio_t       run_prio;
  logic        present;
  logic        wake_hit;

  assign nmi_mask  = nmi_en_i ? onehot(nmi_sel_i) : SRC_NONE;
  assign ack_mask  = irq_ack_i ? core_req_q : SRC_NONE;
  assign done_mask = (irq_done_i && act_valid) ? onehot(act_idx) : SRC_NONE;
  assign rise      = src_i & ~src_q & ~nmi_mask;
  // the line being acknowledged drops out now so it is not shown twice
  assign cand      = pending_q & irq_en_i & ~nmi_mask & ~ack_mask;

  prio_pick pend_pick (
    .cand_i  (cand),
    .prio_i  (irq_prio_i),
    .valid_o (win_valid),
    .idx_o   (win_idx),
    .prio_o  (win_prio)
  );

  // running level is the most urgent handler still in service
  prio_pick act_pick (
    .cand_i  (active_q),
    .prio_i  (irq_prio_i),
    .valid_o (act_valid),
    .idx_o   (act_idx),
    .prio_o  (act_prio)
  );

  // an ack in flight already outranks every active handler
  assign run_valid = irq_ack_i | act_valid;
  assign run_prio  = irq_ack_i ? core_prio_q : act_prio;

  assign present    = (state_q == PWR_RUN) && win_valid && (!run_valid || win_prio < run_prio);
  assign core_req_d = present ? onehot(win_idx) : SRC_NONE;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      src_q <= SRC_NONE;
    end else begin
      src_q <= src_i;
    end
  end

  // pending held until acknowledged; a new edge wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pending_q <= SRC_NONE;
    end else begin
      pending_q <= (pending_q & ~ack_mask) | rise;
    end
  end

  // nesting stack as a set of in-service sources
  always_ff @(posedge core_clk_i) begin
    if (rst_i || state_q == PWR_CORE_RST) begin
      active_q <= SRC_NONE;
    end else begin
      active_q <= (active_q & ~done_mask) | ack_mask;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      core_req_q  <= SRC_NONE;
      core_prio_q <= PRIO_RESET;
    end else begin
      core_req_q  <= core_req_d;
      core_prio_q <= present ? win_prio : PRIO_RESET;
    end
  end

  // non-maskable routing of the selected source
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= nmi_en_i && src_i[nmi_sel_i];
    end
  end

  // wake detector stays live in both sleep states
  assign wake_hit = |(src_i & wake_en_i);

  always_comb begin
    state_d = state_q;
    case (state_q)
      PWR_RUN:      if (sleep_req_i) state_d = ret_mode_i ? PWR_RET : PWR_SLEEP;
      PWR_SLEEP:    if (wake_hit) state_d = PWR_RUN;
      PWR_RET:      if (wake_hit) state_d = PWR_CORE_RST;
      PWR_CORE_RST: if (rst_cnt_q == CNT_RESET) state_d = PWR_RUN;
      default:      state_d = PWR_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= PWR_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rst_cnt_q <= CNT_RESET;
    end else if (state_q == PWR_RET) begin
      rst_cnt_q <= RST_CNT_W'(CORE_RST_CYC - 1);
    end else if (state_q == PWR_CORE_RST && rst_cnt_q != CNT_RESET) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end
  end

  // retention held across the core reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wake_q     <= 1'b0;
      asleep_q   <= 1'b0;
      core_rst_q <= 1'b0;
      retain_q   <= 1'b0;
    end else begin
      wake_q     <= (state_q == PWR_SLEEP || state_q == PWR_RET) && wake_hit;
      asleep_q   <= state_d == PWR_SLEEP || state_d == PWR_RET;
      core_rst_q <= state_d == PWR_CORE_RST;
      retain_q   <= state_d == PWR_RET || state_d == PWR_CORE_RST;
    end
  end

  assign nmi_o           = nmi_q;
  assign core_req_o      = core_req_q;
  assign core_req_prio_o = core_prio_q;
  assign wake_o          = wake_q;
  assign core_asleep_o   = asleep_q;
  assign core_rst_o      = core_rst_q;
  assign ram_retain_o    = retain_q;

  // checking helpers: an independent scan for a better candidate
  logic beaten;
  always_comb begin
    beaten = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (cand[i] && present && irq_prio_i[i] < win_prio) begin
        beaten = 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  line_match_a: assert property (
    $onehot0(core_req_o) && ((core_req_o & ~$past(pending_q)) == SRC_NONE))
    else $error("request line without a pending source of the same index");
  level_win_a: assert property (
    !beaten)
    else $error("a more urgent pending source was passed over");
  nmi_route_a: assert property (
    (nmi_en_i && src_i[nmi_sel_i]) |=> nmi_o)
    else $error("selected source did not reach the non-maskable output");
  nmi_excl_a: assert property (
    nmi_en_i && $stable(nmi_sel_i) && $stable(nmi_en_i) |=> !core_req_o[$past(nmi_sel_i)])
    else $error("non-maskable source appeared on a request line");
  sleep_wake_a: assert property (
    (state_q == PWR_SLEEP && wake_hit) |=> wake_o && !core_asleep_o)
    else $error("enabled source did not wake the core");
  preempt_only_a: assert property (
    (|core_req_o && act_valid) |-> core_req_prio_o < act_prio)
    else $error("request presented without out-ranking the running level");
  fixed_latency_a: assert property (
    ($rose(src_i[0]) && irq_en_i[0] && !nmi_en_i && state_q == PWR_RUN
     && pending_q == SRC_NONE && active_q == SRC_NONE && !irq_ack_i && !sleep_req_i)
    |-> ##2 core_req_o[0])
    else $error("lone request not presented two cycles after its edge");
  ret_core_rst_a: assert property (
    (state_q == PWR_RET && wake_hit) |=> (core_rst_o && ram_retain_o)[*8])
    else $error("core reset on retention exit too short or retention dropped");
  held_disabled_a: assert property (
    (pending_q[4] && !irq_en_i[4] && !irq_ack_i) |=> pending_q[4] && !core_req_o[4])
    else $error("disabled request was lost or presented");

  nested_c: cover property (act_valid && |core_req_o);
  sleep_wake_c: cover property (state_q == PWR_SLEEP ##1 wake_o);
  ret_exit_c: cover property ($fell(core_rst_o) && ram_retain_o == 1'b0);

endmodule

// ---- rtl/irq_wake_pkg.sv ----
// Purpose: shared constants and types for the core interrupt and wake logic
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes:   priority 0 is the most urgent level
package irq_wake_pkg;

  localparam int NUM_SRC         = 8;
  localparam int SRC_IDX_W       = 3;
  localparam int NUM_PRIO_LEVELS = 8;
  localparam int PRIO_W          = 3;

  localparam int CLK_PERIOD_NS   = 5;
  // core reset time on leaving retention sleep; least time, rounded up
  localparam int CORE_RST_NS     = 50;
  localparam int CORE_RST_CYC    = (CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W       = 4;

  localparam logic [NUM_SRC-1:0] SRC_NONE    = 8'h00;
  localparam logic [PRIO_W-1:0]  PRIO_RESET  = 3'h7;
  localparam logic [RST_CNT_W-1:0] CNT_RESET = 4'h0;

  typedef logic [NUM_SRC-1:0]             src_vec_t;
  typedef logic [NUM_SRC-1:0][PRIO_W-1:0] prio_vec_t;
  typedef logic [SRC_IDX_W-1:0]           src_idx_t;
  typedef logic [PRIO_W-1:0]              prio_t;

  typedef enum logic [3:0] {
    PWR_RUN      = 4'h1,
    PWR_SLEEP    = 4'h2,
    PWR_RET      = 4'h4,
    PWR_CORE_RST = 4'h8
  } pwr_state_t;

  function automatic src_vec_t onehot(input src_idx_t idx);
    src_vec_t v;
    v      = SRC_NONE;
    v[idx] = 1'b1;
    return v;
  endfunction

endpackage

// ---- rtl/prio_pick.sv ----
// Purpose: pick the most urgent set bit of a source vector
// Assumes: lower priority value is more urgent
// Notes:   ties go to the lower source index, so the choice is deterministic
module prio_pick (
  input  wire irq_wake_pkg::src_vec_t  cand_i,
  input  wire irq_wake_pkg::prio_vec_t prio_i,
  output logic                         valid_o,
  output irq_wake_pkg::src_idx_t       idx_o,
  output irq_wake_pkg::prio_t          prio_o
);
  import irq_wake_pkg::*;

  always_comb begin
    valid_o = 1'b0;
    idx_o   = '0;
    prio_o  = PRIO_RESET;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (cand_i[i] && (!valid_o || prio_i[i] < prio_o)) begin
        valid_o = 1'b1;
        idx_o   = SRC_IDX_W'(i);
        prio_o  = prio_i[i];
      end
    end
  end

endmodule
